// File: common/itei_map.vh
`ifndef ITEI_MAP_VH
`define ITEI_MAP_VH

// Address bit positions
`define ITEI_A_PRE_LO      0
`define ITEI_A_PRE_HI      1
`define ITEI_A_TMR_SEL     2
`define ITEI_A_TMR_IRQ     3
`define ITEI_A_TMR_WR      4
`define ITEI_A_FLAG_RD     0
`define ITEI_A_EDGE_POS    0
`define ITEI_A_EDGE_EN     1

// Prescale ratio codes
`define ITEI_RATIO_DIV1    2'h0
`define ITEI_RATIO_DIV8    2'h1
`define ITEI_RATIO_DIV64   2'h2
`define ITEI_RATIO_DIV1024 2'h3

// Prescaler reload values, ratio minus one, then the zero and decrement constants
`define ITEI_PRE_DIV1      10'h000
`define ITEI_PRE_DIV8      10'h007
`define ITEI_PRE_DIV64     10'h03f
`define ITEI_PRE_DIV1024   10'h3ff
`define ITEI_PRE_ZERO      10'h000
`define ITEI_PRE_ONE       10'h001

// Flag register layout
`define ITEI_FLAG_TMR_BIT  7
`define ITEI_FLAG_EDGE_BIT 6
`define ITEI_FLAG_PAD      6'h00
`define ITEI_FLAG_IDLE     8'h00

// Counter constants and reset values
`define ITEI_CNT_ZERO      8'h00
`define ITEI_CNT_ONE       8'h01
`define ITEI_CNT_RESET     8'hff
`define ITEI_RATIO_RESET   2'h3
`define ITEI_DATA_RESET    8'h00

`endif

// File: design/itei_sync2.v
`timescale 1ns/10ps

module itei_sync2 (
  core_clk,
  resetn,
  async_in,
  sync_out
);
  input  wire core_clk;
  input  wire resetn;
  input  wire async_in;
  output wire sync_out;

  reg         meta_q;
  reg         sync_q;

  // Two-stage synchroniser, idle high
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

// File: design/itei_prescaler.v
`timescale 1ns/10ps
`include "itei_map.vh"

module itei_prescaler (
  core_clk,
  resetn,
  load,
  ratio,
  fast,
  tick
);
  input  wire       core_clk;
  input  wire       resetn;
  input  wire       load;
  input  wire [1:0] ratio;
  input  wire       fast;
  output wire       tick;

  reg  [9:0] pre_q;
  reg  [9:0] pre_d;
  reg  [9:0] reload;

  // Reload value for the selected ratio
  always @* begin
    case (ratio)
      `ITEI_RATIO_DIV1:    reload = `ITEI_PRE_DIV1;
      `ITEI_RATIO_DIV8:    reload = `ITEI_PRE_DIV8;
      `ITEI_RATIO_DIV64:   reload = `ITEI_PRE_DIV64;
      default:             reload = `ITEI_PRE_DIV1024;
    endcase
  end

  // Tick every ratio clocks, every clock after timeout
  assign tick = fast | (pre_q == `ITEI_PRE_ZERO);

  always @* begin
    if (load)
      pre_d = `ITEI_PRE_ZERO;
    else if (pre_q == `ITEI_PRE_ZERO)
      pre_d = reload;
    else
      pre_d = pre_q - `ITEI_PRE_ONE;
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      pre_q <= `ITEI_PRE_ZERO;
    else
      pre_q <= pre_d;
  end

endmodule

// File: design/itei_timer_top.v
`timescale 1ns/10ps
`include "itei_map.vh"

module itei_timer_top (
  core_clk,
  resetn,
  addr,
  register_select,
  chip_select_high,
  chip_select_low_n,
  read_write,
  data_in,
  data_out,
  data_oe,
  irq_n_out,
  irq_oe,
  port_a_bit7_edge_line,
  ram_select,
  port_reg_select,
  port_reg_index
);
  input  wire       core_clk;
  input  wire       resetn;
  input  wire [6:0] addr;
  input  wire       register_select;
  input  wire       chip_select_high;
  input  wire       chip_select_low_n;
  input  wire       read_write;
  input  wire [7:0] data_in;
  output wire [7:0] data_out;
  output wire       data_oe;
  output wire       irq_n_out;
  output wire       irq_oe;
  input  wire       port_a_bit7_edge_line;
  output wire       ram_select;
  output wire       port_reg_select;
  output wire [1:0] port_reg_index;

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  wire       chip_sel;
  wire       io_sel;
  wire       tmr_sec;
  wire       wr_timer;
  wire       wr_edge;
  wire       rd_timer;
  wire       rd_flags;
  wire       acc_timer;

  assign chip_sel = chip_select_high & ~chip_select_low_n;
  assign io_sel   = chip_sel & register_select;

  // Timer and flag section
  assign tmr_sec = io_sel & addr[`ITEI_A_TMR_SEL];

  // Timer load
  assign wr_timer = tmr_sec & ~read_write
                  & addr[`ITEI_A_TMR_WR];

  // Edge control load
  assign wr_edge  = tmr_sec & ~read_write
                  & ~addr[`ITEI_A_TMR_WR];

  // Counter read and flag read
  assign rd_timer = tmr_sec & read_write
                  & ~addr[`ITEI_A_FLAG_RD];
  assign rd_flags = tmr_sec & read_write
                  & addr[`ITEI_A_FLAG_RD];

  assign acc_timer = wr_timer | rd_timer;

  // Selects toward storage and port registers kept elsewhere
  assign ram_select      = chip_sel & ~register_select;
  assign port_reg_select = io_sel & ~addr[`ITEI_A_TMR_SEL];
  assign port_reg_index  = addr[`ITEI_A_PRE_HI:`ITEI_A_PRE_LO];

  ////////////////////////////////////////////////////////////////////////
  // Timer state

  reg  [7:0] count_q;
  reg  [7:0] count_d;
  reg  [1:0] ratio_q;
  reg        fast_q;
  reg        tmr_flag_q;
  reg        tmr_flag_d;
  reg        tmr_irq_en_q;
  reg        tmr_irq_en_d;
  wire       tick;
  wire       count_zero;
  wire       timeout;

  itei_prescaler u_prescaler (
    .core_clk (core_clk),
    .resetn   (resetn),
    .load     (wr_timer),
    .ratio    (ratio_q),
    .fast     (fast_q),
    .tick     (tick)
  );

  assign count_zero = (count_q == `ITEI_CNT_ZERO);

  // Timeout on the tick after zero, unless reloaded
  assign timeout = tick & count_zero & ~wr_timer;

  ////////////////////////////////////////////////////////////////////////
  // Interval counter

  always @* begin
    if (wr_timer)
      count_d = data_in;
    else if (tick)
      count_d = count_q - `ITEI_CNT_ONE;
    else
      count_d = count_q;
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      count_q <= `ITEI_CNT_RESET;
    else
      count_q <= count_d;
  end

  // Prescale ratio chosen on load
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ratio_q <= `ITEI_RATIO_RESET;
    end else if (wr_timer) begin
      ratio_q <= addr[`ITEI_A_PRE_HI:`ITEI_A_PRE_LO];
    end
  end

  // Single-clock rate from timeout until the next load
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fast_q <= 1'b0;
    end else if (wr_timer) begin
      fast_q <= 1'b0;
    end else if (timeout) begin
      fast_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timer flag and enable

  // Set wins over the access clear
  always @* begin
    if (timeout)
      tmr_flag_d = 1'b1;
    else if (acc_timer)
      tmr_flag_d = 1'b0;
    else
      tmr_flag_d = tmr_flag_q;
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      tmr_flag_q <= 1'b0;
    else
      tmr_flag_q <= tmr_flag_d;
  end

  // Timer irq enable from bit 3 on any counter access
  always @* begin
    if (acc_timer)
      tmr_irq_en_d = addr[`ITEI_A_TMR_IRQ];
    else
      tmr_irq_en_d = tmr_irq_en_q;
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      tmr_irq_en_q <= 1'b0;
    else
      tmr_irq_en_q <= tmr_irq_en_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Edge sense

  wire       edge_sync;
  reg        edge_prev_q;
  reg        edge_pos_q;
  reg        edge_pos_d;
  reg        edge_irq_en_q;
  reg        edge_irq_en_d;
  reg        edge_flag_q;
  reg        edge_flag_d;
  wire       edge_seen;

  // Pin is sampled regardless of port direction
  itei_sync2 u_edge_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .async_in (port_a_bit7_edge_line),
    .sync_out (edge_sync)
  );

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      edge_prev_q <= 1'b1;
    else
      edge_prev_q <= edge_sync;
  end

  // Rising or falling transition per polarity
  assign edge_seen = edge_pos_q ? (edge_sync & ~edge_prev_q)
                                : (~edge_sync & edge_prev_q);

  // Edge control, data value ignored
  always @* begin
    if (wr_edge) begin
      edge_irq_en_d = addr[`ITEI_A_EDGE_EN];
      edge_pos_d    = addr[`ITEI_A_EDGE_POS];
    end else begin
      edge_irq_en_d = edge_irq_en_q;
      edge_pos_d    = edge_pos_q;
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      edge_irq_en_q <= 1'b0;
      edge_pos_q    <= 1'b0;
    end else begin
      edge_irq_en_q <= edge_irq_en_d;
      edge_pos_q    <= edge_pos_d;
    end
  end

  // Set wins over the flag-read clear
  always @* begin
    if (edge_seen)
      edge_flag_d = 1'b1;
    else if (rd_flags)
      edge_flag_d = 1'b0;
    else
      edge_flag_d = edge_flag_q;
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      edge_flag_q <= 1'b0;
    else
      edge_flag_q <= edge_flag_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt request

  reg        irq_oe_q;
  wire       tmr_irq_req;
  wire       edge_irq_req;
  wire       irq_req;

  // Next-state enables, so an enable change acts on the same edge
  assign tmr_irq_req  = tmr_flag_d & tmr_irq_en_d;
  assign edge_irq_req = edge_flag_d & edge_irq_en_d;
  assign irq_req      = tmr_irq_req | edge_irq_req;

  // Open drain: drives low only, released otherwise
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      irq_oe_q <= 1'b0;
    else
      irq_oe_q <= irq_req;
  end

  assign irq_oe    = irq_oe_q;
  assign irq_n_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Read data

  reg  [7:0] flag_word;
  reg  [7:0] rdata_d;
  reg  [7:0] data_out_q;
  reg        data_oe_q;

  // Flag register image, unused bits read zero
  always @* begin
    flag_word                      = `ITEI_FLAG_IDLE;
    flag_word[`ITEI_FLAG_TMR_BIT]  = tmr_flag_q;
    flag_word[`ITEI_FLAG_EDGE_BIT] = edge_flag_q;
  end

  always @* begin
    if (rd_flags) begin
      rdata_d = flag_word;
    end else if (rd_timer) begin
      rdata_d = count_q;
    end else begin
      rdata_d = `ITEI_DATA_RESET;
    end
  end

  // Data captured on the access edge, driven for one cycle
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      data_out_q <= `ITEI_DATA_RESET;
      data_oe_q  <= 1'b0;
    end else begin
      data_out_q <= rdata_d;
      data_oe_q  <= rd_flags | rd_timer;
    end
  end

  assign data_out = data_out_q;
  assign data_oe  = data_oe_q;

endmodule

// File: test/itei_timer_asserts.sv
`timescale 1ns/10ps
module itei_timer_asserts (
  input wire       core_clk,
  input wire       resetn,
  input wire [6:0] addr,
  input wire       register_select,
  input wire       chip_select_high,
  input wire       chip_select_low_n,
  input wire       read_write,
  input wire [7:0] data_in,
  input wire [7:0] data_out,
  input wire       data_oe,
  input wire       irq_n_out,
  input wire       irq_oe,
  input wire       ram_select,
  input wire       port_reg_select,
  input wire [1:0] port_reg_index
);
  wire sel = chip_select_high & ~chip_select_low_n;
  wire acc = sel & register_select & addr[2];
  wire rd  = acc & read_write;

  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////////
  // Timer access, an idle edge, then a flag read
  sequence flag_rd_s;
    rd && addr[0];
  endsequence
  sequence tmr_rd_s;
    rd && !addr[0] ##1 !acc && data_out > 8'h02;
  endsequence
  sequence tmr_wr_s;
    acc && !read_write && addr[4] && data_in > 8'h02 ##1 !acc;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  read_ans_a: assert property (
    rd |=> data_oe)
    else $error("read not answered");
  write_quiet_a: assert property (
    !rd |=> !data_oe)
    else $error("data driven without read");
  bus_idle_a: assert property (
    !data_oe |-> data_out == 8'h00)
    else $error("data not idle");
  ram_dec_a: assert property (
    ram_select == (sel && !register_select))
    else $error("bad ram select");
  port_dec_a: assert property (
    port_reg_select == (sel && register_select && !addr[2])
    && port_reg_index == addr[1:0])
    else $error("bad port select");
  irq_level_a: assert property (
    irq_n_out == 1'b0)
    else $error("irq data not low");
  flag_pad_a: assert property (
    flag_rd_s |=> data_out[5:0] == 6'h00)
    else $error("flag pad bits set");
  rd_clear_a: assert property (
    tmr_rd_s ##1 flag_rd_s |=> !data_out[7])
    else $error("timer read left flag");
  wr_clear_a: assert property (
    tmr_wr_s ##1 flag_rd_s |=> !data_out[7])
    else $error("timer write left flag");
  irq_flag_a: assert property (
    rd && addr[0] && irq_oe |=> data_out[7:6] != 2'h0)
    else $error("irq driven with no flag");
endmodule

bind itei_timer_top itei_timer_asserts i_itei_timer_asserts (
  .core_clk(core_clk), .resetn(resetn), .addr(addr),
  .register_select(register_select), .chip_select_high(chip_select_high),
  .chip_select_low_n(chip_select_low_n), .read_write(read_write),
  .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
  .irq_n_out(irq_n_out), .irq_oe(irq_oe), .ram_select(ram_select),
  .port_reg_select(port_reg_select), .port_reg_index(port_reg_index));

// File: test/itei_cpu_model.sv
`timescale 1ns/10ps
module itei_cpu_model (
  input  logic       core_clk,
  input  logic [7:0] data_out,
  output logic [6:0] addr,
  output logic       register_select,
  output logic       chip_select_high,
  output logic       chip_select_low_n,
  output logic       read_write,
  output logic [7:0] data_in
);
  initial begin
    addr = 7'h00;
    register_select = 1'b0;
    chip_select_high = 1'b0;
    chip_select_low_n = 1'b1;
    read_write = 1'b1;
    data_in = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One access over one rising edge; on release the chip selects drop and addr and data_in show inverse values
  task automatic xfer(input logic rs, input logic rw,
                      input logic [6:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(negedge core_clk);
    addr = a;
    register_select = rs;
    read_write = rw;
    data_in = d;
    chip_select_high = 1'b1;
    chip_select_low_n = 1'b0;
    @(negedge core_clk);
    q = data_out;
    chip_select_high = 1'b0;
    chip_select_low_n = 1'b1;
    addr = ~a;
    data_in = ~d;
  endtask
endmodule

// File: test/itei_timer_top_test.sv
`timescale 1ns/10ps
module itei_timer_top_test;
  logic       core_clk;
  logic       resetn;
  logic       pin;
  wire  [6:0] addr;
  wire        rs;
  wire        cs_hi;
  wire        cs_lo_n;
  wire        rw;
  wire  [7:0] data_in;
  wire  [7:0] data_out;
  wire        data_oe;
  wire        irq_oe;
  int         num_errors;
  int         total_checks;
  logic [7:0] q;

  itei_timer_top i_itei_timer_top (
    .core_clk(core_clk), .resetn(resetn), .addr(addr),
    .register_select(rs), .chip_select_high(cs_hi),
    .chip_select_low_n(cs_lo_n), .read_write(rw), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .irq_n_out(),
    .irq_oe(irq_oe), .port_a_bit7_edge_line(pin), .ram_select(),
    .port_reg_select(), .port_reg_index());
  itei_cpu_model i_itei_cpu_model (
    .core_clk(core_clk), .data_out(data_out), .addr(addr),
    .register_select(rs), .chip_select_high(cs_hi),
    .chip_select_low_n(cs_lo_n), .read_write(rw), .data_in(data_in));

  always #5 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [6:0] a);
    i_itei_cpu_model.xfer(1'b1, 1'b1, a, 8'h00, q);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_itei_cpu_model.xfer(1'b1, 1'b0, a, d, q);
  endtask
  task automatic pin_wait(input logic v);
    pin = v;
    repeat (4) @(negedge core_clk);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic reset_state();
    rd(7'h05);
    chk(q, 8'h00);
    pin_wait(1'b0);
    chk({7'h00, irq_oe}, 8'h00);
    rd(7'h05);
    chk(q, 8'h40);
    rd(7'h05);
    chk(q, 8'h00);
  endtask
  task automatic edge_modes();
    for (int m = 0; m < 4; m++) begin
      pin_wait(m[0]);
      rd(7'h05);
      wr(7'h04 | 7'(m), 8'h5a);
      pin_wait(!m[0]);
      rd(7'h05);
      chk(q, 8'h00);
      pin_wait(m[0]);
      chk({7'h00, irq_oe}, {7'h00, m[1]});
      rd(7'h05);
      chk(q, 8'h40);
      chk({7'h00, irq_oe}, 8'h00);
    end
  endtask
  task automatic ratios();
    int div;
    for (int r = 0; r < 4; r++) begin
      div = (r == 3) ? 1024 : 1 << (3 * r);
      wr(7'h14 | 7'(r), 8'h10);
      rd(7'h05);
      chk(q, 8'h00);
      repeat (3 * div - 2) @(negedge core_clk);
      rd(7'h04);
      chk(q, 8'h0c);
    end
  endtask
  task automatic timeout();
    int n;
    wr(7'h1d, 8'h02);
    n = 0;
    while (irq_oe !== 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    chk(8'(n), 8'h11);
    rd(7'h05);
    chk(q, 8'h80);
    chk({7'h00, irq_oe}, 8'h01);
    rd(7'h04);
    chk(q, 8'hfc);
    chk({7'h00, irq_oe}, 8'h00);
    rd(7'h05);
    chk(q, 8'h00);
    wr(7'h14, 8'h02);
    @(negedge core_clk);
    rd(7'h04);
    chk(q, 8'h00);
    rd(7'h05);
    chk(q, 8'h80);
    rd(7'h04);
    chk(q, 8'hfc);
    rd(7'h05);
    chk(q, 8'h00);
  endtask
  task automatic refused();
    i_itei_cpu_model.xfer(1'b0, 1'b1, 7'h04, 8'h00, q);
    chk({7'h00, data_oe}, 8'h00);
    rd(7'h00);
    chk({7'h00, data_oe}, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    resetn = 1'b0;
    pin = 1'b1;
    num_errors = 0;
    total_checks = 0;
    repeat (16) @(negedge core_clk);
    chk({7'h00, data_oe}, 8'h00);
    resetn = 1'b1;
    reset_state();
    edge_modes();
    ratios();
    timeout();
    refused();
    final_report();
  end
  initial begin
    #100000;
    num_errors++;
    final_report();
  end
endmodule
